// File: scl_pkg.sv
/*
 * Package for the strap configuration latch: register map, field
 * positions, reset values and state encodings.
 * Assumes a single 40 MHz clock domain and an AXI4-Lite register bus.
 */
package scl_pkg;

	// Register byte offsets
	localparam logic [7:0] SCL_STRAP_RAW_OFS = 8'h00;
	localparam logic [7:0] SCL_ACTIVE_CFG_OFS = 8'h04;
	localparam logic [7:0] SCL_CONTROL_OFS = 8'h08;
	localparam logic [7:0] SCL_STATUS_OFS = 8'h0c;

	// Strap vector field positions
	localparam int SCL_ADDR0_POS = 0;
	localparam int SCL_ADDR1_POS = 1;
	localparam int SCL_CLKROLE_POS = 2;
	localparam int SCL_RXVSEL_POS = 3;
	localparam int SCL_ANDIS_POS = 4;
	localparam int SCL_STRAP_W = 5;

	// Control register fields
	localparam int SCL_CTL_SWRST_POS = 0;
	localparam int SCL_CTL_HARDRST_POS = 1;

	// Status register fields
	localparam int SCL_STS_VALID_POS = 0;
	localparam int SCL_STS_BUSY_POS = 1;

	// Reset values: every strap defaults to mode 0
	localparam logic [SCL_STRAP_W-1:0] SCL_STRAP_RST = 5'h00;

	// Settling time before sampling after reset release
	localparam int SCL_CLK_MHZ = 40;
	localparam int SCL_SETTLE_NS = 200;
	localparam int SCL_SETTLE_CYC = (SCL_SETTLE_NS * SCL_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SCL_SETTLE_CNT = 4'(SCL_SETTLE_CYC);

	// AXI response codes
	localparam logic [1:0] SCL_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCL_RESP_SLVERR = 2'h2;

	// Loader sequence, Gray coded along the usual path
	typedef enum logic [1:0] {
		SCL_ST_SETTLE = 2'b00,
		SCL_ST_SAMPLE = 2'b01,
		SCL_ST_RUN = 2'b11,
		SCL_ST_RELOAD = 2'b10
	} scl_state_type;

endpackage

// File: scl_strap_if.sv
/*
 * Interface carrying synchronised strap levels between the pin
 * synchroniser and the configuration latch.
 * Assumes both ends run on the same clock.
 */
interface scl_strap_if;
	import scl_pkg::*;
	logic [SCL_STRAP_W-1:0] level;
	modport src (output level);
	modport dst (input level);
endinterface

// File: scl_pin_sync.sv
/*
 * Two-stage synchroniser for the strap pins.
 * Assumes pins are asynchronous and static once the board settles.
 */
module scl_pin_sync
	import scl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [SCL_STRAP_W-1:0] pins_in,
	scl_strap_if.src strap_out
);
	typedef struct packed {
		logic [SCL_STRAP_W-1:0] meta;
		logic [SCL_STRAP_W-1:0] sync;
	} scl_sync_state_type;

	scl_sync_state_type state_q;
	scl_sync_state_type state_d;

	// First stage feeds only the second
	always_comb begin
		state_d = state_q;
		state_d.meta = pins_in;
		state_d.sync = state_q.meta;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign strap_out.level = state_q.sync;
endmodule

// File: scl_strap_config_latch.sv
/*
 * Strap configuration latch: samples the strap pins after a hard reset,
 * holds them, and reloads the active settings on a software reset.
 * Assumes pins are already two-level logic from the pad comparators
 * and that software reaches the registers over AXI4-Lite.
 */
module scl_strap_config_latch
	import scl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic receive_data_bit0_pin_in,
	input wire logic crs_valid_pin_in,
	input wire logic receive_data_bit1_pin_in,
	input wire logic refclk_out_light_pin_in,
	input wire logic status_light_zero_pin_in,
	input wire logic sw_reset_in,
	output logic [1:0] mgmt_addr_out,
	output logic clk_master_out,
	output logic rx_valid_plain_out,
	output logic autoneg_enable_out,
	output logic force_100m_out,
	output logic config_valid_out,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		scl_state_type st;
		logic [3:0] settle;
		logic [SCL_STRAP_W-1:0] captured;
		logic [SCL_STRAP_W-1:0] active;
		logic valid;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic swrst_req;
		logic hardrst_req;
	} scl_top_state_type;

	scl_top_state_type state_q;
	scl_top_state_type state_d;
	scl_strap_if strap_bus();
	logic [SCL_STRAP_W-1:0] pin_vec;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_word;
	logic rd_ok;
	logic ctl_wr;

	// Pin vector in strap field order
	always_comb begin
		pin_vec = '0;
		pin_vec[SCL_ADDR0_POS] = receive_data_bit0_pin_in;
		pin_vec[SCL_ADDR1_POS] = crs_valid_pin_in;
		pin_vec[SCL_CLKROLE_POS] = receive_data_bit1_pin_in;
		pin_vec[SCL_RXVSEL_POS] = refclk_out_light_pin_in;
		pin_vec[SCL_ANDIS_POS] = status_light_zero_pin_in;
	end

	// two-level sampling
	// Pads have already sliced at the thresholds; we just synchronise
	scl_pin_sync u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pins_in(pin_vec),
		.strap_out(strap_bus.src)
	);

	assign wr_fire = state_q.aw_got && state_q.w_got && !state_q.bvalid;
	assign rd_fire = s_axi_arvalid && !state_q.rvalid;
	// Control write landing now; the loader keeps it when it clears a request
	assign ctl_wr = wr_fire && (state_q.awaddr == SCL_CONTROL_OFS) && state_q.wstrb[0];

	// Read decode, unmapped returns SLVERR with zero data
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			SCL_STRAP_RAW_OFS: rd_word[SCL_STRAP_W-1:0] = state_q.captured;
			SCL_ACTIVE_CFG_OFS: rd_word[SCL_STRAP_W-1:0] = state_q.active;
			SCL_CONTROL_OFS: rd_word = 32'h0000_0000;
			SCL_STATUS_OFS: begin
				rd_word[SCL_STS_VALID_POS] = state_q.valid;
				rd_word[SCL_STS_BUSY_POS] = (state_q.st != SCL_ST_RUN);
			end
			default: rd_ok = 1'b0;
		endcase
	end

	// Next-state logic for loader and bus slave
	always_comb begin
		state_d = state_q;
		// Write address and data taken independently
		if (s_axi_awvalid && !state_q.aw_got) begin
			state_d.aw_got = 1'b1;
			state_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_q.w_got) begin
			state_d.w_got = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			state_d.aw_got = 1'b0;
			state_d.w_got = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = SCL_RESP_OKAY;
			case (state_q.awaddr)
				SCL_CONTROL_OFS: begin
					if (state_q.wstrb[0]) begin
						state_d.swrst_req = state_q.wdata[SCL_CTL_SWRST_POS];
						state_d.hardrst_req = state_q.wdata[SCL_CTL_HARDRST_POS];
					end
				end
				SCL_STRAP_RAW_OFS, SCL_ACTIVE_CFG_OFS, SCL_STATUS_OFS: ;
				default: state_d.bresp = SCL_RESP_SLVERR;
			endcase
		end
		if (state_q.bvalid && s_axi_bready) begin
			state_d.bvalid = 1'b0;
		end
		if (rd_fire) begin
			state_d.rvalid = 1'b1;
			state_d.rdata = rd_word;
			state_d.rresp = rd_ok ? SCL_RESP_OKAY : SCL_RESP_SLVERR;
		end else if (state_q.rvalid && s_axi_rready) begin
			state_d.rvalid = 1'b0;
		end

		// Loader sequence
		case (state_q.st)
			SCL_ST_SETTLE: begin
				// Wait out synchroniser and pad settling before trusting pins
				if (state_q.settle == SCL_SETTLE_CNT) begin
					state_d.st = SCL_ST_SAMPLE;
				end else begin
					state_d.settle = state_q.settle + 4'h1;
				end
			end
			SCL_ST_SAMPLE: begin
				state_d.captured = strap_bus.level;
				state_d.active = strap_bus.level;
				state_d.valid = 1'b1;
				state_d.st = SCL_ST_RUN;
			end
			SCL_ST_RUN: begin
				if (state_q.hardrst_req) begin
					// hard reset resamples
					// A write in the clearing cycle wins, so no request is lost
					state_d.hardrst_req = ctl_wr && state_q.wdata[SCL_CTL_HARDRST_POS];
					state_d.swrst_req = ctl_wr && state_q.wdata[SCL_CTL_SWRST_POS];
					state_d.valid = 1'b0;
					state_d.settle = 4'h0;
					state_d.st = SCL_ST_SETTLE;
				end else if (state_q.swrst_req || sw_reset_in) begin
					state_d.swrst_req = ctl_wr && state_q.wdata[SCL_CTL_SWRST_POS];
					state_d.st = SCL_ST_RELOAD;
				end
			end
			SCL_ST_RELOAD: begin
				state_d.active = state_q.captured;
				state_d.st = SCL_ST_RUN;
			end
			default: state_d.st = SCL_ST_SETTLE;
		endcase
	end

	// straps default to mode 0 at reset
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= '{st: SCL_ST_SETTLE, captured: SCL_STRAP_RST, active: SCL_STRAP_RST,
				bresp: SCL_RESP_OKAY, rresp: SCL_RESP_OKAY, default: '0};
		end else begin
			state_q <= state_d;
		end
	end

	assign mgmt_addr_out = {state_q.active[SCL_ADDR1_POS], state_q.active[SCL_ADDR0_POS]};
	assign clk_master_out = !state_q.active[SCL_CLKROLE_POS];
	assign rx_valid_plain_out = state_q.active[SCL_RXVSEL_POS];
	assign autoneg_enable_out = !state_q.active[SCL_ANDIS_POS];
	assign force_100m_out = state_q.active[SCL_ANDIS_POS];
	assign config_valid_out = state_q.valid;

	// Bus handshakes
	assign s_axi_awready = !state_q.aw_got;
	assign s_axi_wready = !state_q.w_got;
	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_arready = !state_q.rvalid;
	assign s_axi_rvalid = state_q.rvalid;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
endmodule

// File: scl_board_straps.sv
/* Board strap resistors for the strap latch.
   Assumes pins are static and already sliced to logic levels. */
module scl_board_straps (
	input wire logic [4:0] mode_in,
	output logic [4:0] pins_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// two-level straps
	// Pull-up gives mode 1, pull-down mode 0; never floats
	assign pins_out = mode_in;
endmodule

// File: scl_strap_config_latch_assertions.sv
/* Checker for the strap latch ports.
   Assumes pins stay stable around capture. */
module scl_strap_config_latch_assertions (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic receive_data_bit0_pin_in,
	input wire logic crs_valid_pin_in,
	input wire logic receive_data_bit1_pin_in,
	input wire logic refclk_out_light_pin_in,
	input wire logic status_light_zero_pin_in,
	input wire logic [1:0] mgmt_addr_out,
	input wire logic clk_master_out,
	input wire logic rx_valid_plain_out,
	input wire logic autoneg_enable_out,
	input wire logic force_100m_out,
	input wire logic config_valid_out,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	addr_map_a: assert property ($rose(config_valid_out) |->
		mgmt_addr_out == {crs_valid_pin_in, receive_data_bit0_pin_in}) else $error("address strap wrong");
	clk_role_a: assert property ($rose(config_valid_out) |->
		clk_master_out == !receive_data_bit1_pin_in) else $error("clock role wrong");
	rxv_sel_a: assert property ($rose(config_valid_out) |->
		rx_valid_plain_out == refclk_out_light_pin_in) else $error("rx valid select wrong");
	force_map_a: assert property ($rose(config_valid_out) |->
		force_100m_out == status_light_zero_pin_in) else $error("force 100M wrong");
	an_pair_a: assert property (autoneg_enable_out != force_100m_out) else $error("autoneg pair wrong");
	cfg_hold_a: assert property (config_valid_out && $past(config_valid_out) |->
		$stable({mgmt_addr_out, clk_master_out, rx_valid_plain_out, force_100m_out})) else $error("config moved");
	capture_time_a: assert property ($rose(rst_b_in) |->
		(!config_valid_out)[*5] ##[1:12] config_valid_out) else $error("capture late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind scl_strap_config_latch scl_strap_config_latch_assertions i_chk (.clk_in, .rst_b_in,
	.receive_data_bit0_pin_in, .crs_valid_pin_in, .receive_data_bit1_pin_in, .refclk_out_light_pin_in,
	.status_light_zero_pin_in, .mgmt_addr_out, .clk_master_out, .rx_valid_plain_out, .autoneg_enable_out,
	.force_100m_out, .config_valid_out, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: strap_config_latch_bench.sv
/* Self-checking bench for the strap latch.
   Assumes the board model holds the pins static between resets. */
module strap_config_latch_bench;
	import scl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst_b_in = 0, sw_reset_in = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, clk_master_out, rx_valid_plain_out, autoneg_enable_out, force_100m_out;
	logic config_valid_out;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, mgmt_addr_out, r;
	logic [4:0] cfg = 5'h00, pins, v;
	int failures = 0, checked = 0;
	scl_board_straps i_board (.mode_in(cfg), .pins_out(pins));
	scl_strap_config_latch i_dut (.clk_in, .rst_b_in, .receive_data_bit0_pin_in(pins[0]),
		.crs_valid_pin_in(pins[1]), .receive_data_bit1_pin_in(pins[2]), .refclk_out_light_pin_in(pins[3]),
		.status_light_zero_pin_in(pins[4]), .sw_reset_in, .mgmt_addr_out, .clk_master_out,
		.rx_valid_plain_out, .autoneg_enable_out, .force_100m_out, .config_valid_out, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// Clock near 40 MHz: half period rounds to 13 ns, 26 ns period
	always #12.5 clk_in = ~clk_in;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// Expected config outputs from a strap vector
	function automatic logic [5:0] expect_cfg(input logic [4:0] s);
		return {s[1:0], !s[2], s[3], !s[4], s[4]};
	endfunction
	// Readies are sampled mid-cycle so the edge that takes them is not raced
	task automatic wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rsp);
		logic aw, wd, b;
		b = 0;
		// Request starts just after a rising edge; first sample precedes the taking edge
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!b) begin
			@(negedge clk_in);
			{aw, wd, b, rsp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk_in);
			if (aw) s_axi_awvalid <= 0;
			if (wd) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rsp);
		logic ar, rv;
		rv = 0;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!rv) begin
			@(negedge clk_in);
			{ar, rv, q, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_in);
			if (ar) s_axi_arvalid <= 0;
			if (rv) s_axi_rready <= 0;
		end
	endtask
	task automatic outs(input logic [4:0] s);
		chk("config", 32'(expect_cfg(s)), 32'({mgmt_addr_out, clk_master_out, rx_valid_plain_out,
			autoneg_enable_out, force_100m_out}));
	endtask
	task automatic complete_run;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		complete_run;
	end
	// Corner vectors first, then random straps with reloads in between
	initial begin
		void'($urandom(31));
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
			cfg <= v;
			rst_b_in <= 0;
			// Long hold at start, short hard resets in mid run
			repeat ((i == 0) ? 16 : 4) @(posedge clk_in);
			rst_b_in <= 1;
			while (config_valid_out !== 1'b1) @(posedge clk_in);
			@(negedge clk_in);
			outs(v);
			rd(SCL_STRAP_RAW_OFS, d, r);
			chk("raw", 32'(v), d);
			rd(SCL_ACTIVE_CFG_OFS, d, r);
			chk("active", 32'(v), d);
			cfg <= ~v;
			sw_reset_in <= 1;
			@(posedge clk_in);
			sw_reset_in <= 0;
			repeat (4) @(posedge clk_in);
			outs(v);
			wr(SCL_CONTROL_OFS, 32'h1, r);
			chk("bresp", 32'(SCL_RESP_OKAY), 32'(r));
			repeat (4) @(posedge clk_in);
			outs(v);
			rd(SCL_STATUS_OFS, d, r);
			chk("status", 32'h1, d);
			rd(SCL_CONTROL_OFS, d, r);
			chk("control", 32'h0, d);
			rd(8'h10, d, r);
			chk("unmapped", 32'(SCL_RESP_SLVERR), 32'(r));
			chk("unmapped data", 32'h0, d);
			wr(8'h10, 32'h1, r);
			chk("unmapped write", 32'(SCL_RESP_SLVERR), 32'(r));
			// Hard reset bit resamples; the pins now show the inverted vector
			wr(SCL_CONTROL_OFS, 32'h2, r);
			chk("hard bresp", 32'(SCL_RESP_OKAY), 32'(r));
			rd(SCL_STATUS_OFS, d, r);
			chk("busy", 32'h2, d);
			while (config_valid_out !== 1'b1) @(posedge clk_in);
			@(negedge clk_in);
			outs(cfg);
			rd(SCL_STRAP_RAW_OFS, d, r);
			chk("raw after hard", 32'(cfg), d);
			$display("test %0d done", i);
		end
		complete_run;
	end
endmodule
